/* File: include/host_port_pkg.sv */
/*
 * Constants shared by both ends of the parallel host port.
 * Assumes a single 100 MHz system clock on both ends.
 */
package host_port_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int NUM_REGS = 16;
	localparam int RESET_MIN_CYCLES = 8;
	localparam int RST_CNT_W = 4;
	localparam logic [3:0] RST_CNT_LIMIT = 4'h8;
	localparam logic [3:0] GP_STATUS_ADDR = 4'h5;
	localparam logic [15:0] REG_RESET_VAL = 16'h0000;
	localparam int STROBE_CYCLES = 2;
	localparam logic [3:0] HOST_RST_CYCLES = 4'ha;
	typedef logic [DATA_W-1:0] word_t;
	typedef logic [ADDR_W-1:0] addr_t;
endpackage : host_port_pkg

/* File: include/host_port_if.sv */
/*
 * Pin bundle between the host and the device.
 * Assumes the bench resolves the shared data wires from the enables.
 */
`timescale 1ns/1ns
interface host_port_if;
	import host_port_pkg::*;
	logic chip_select_low;
	logic write_strobe_low;
	logic read_strobe_low;
	logic reset_in_low;
	logic bus_width_select;
	addr_t register_address;
	word_t host_data_dev_out;
	logic host_data_dev_oe_b;
	word_t host_data_host_out;
	logic host_data_host_oe_b;
	word_t host_data_lines;
	logic interrupt_request_out;
	logic interrupt_oe_b;
	modport device (
		input chip_select_low, write_strobe_low, read_strobe_low,
		input reset_in_low, bus_width_select, register_address,
		input host_data_lines,
		output host_data_dev_out, host_data_dev_oe_b,
		output interrupt_request_out, interrupt_oe_b
	);
	modport host (
		output chip_select_low, write_strobe_low, read_strobe_low,
		output reset_in_low, bus_width_select, register_address,
		output host_data_host_out, host_data_host_oe_b,
		input host_data_lines, interrupt_oe_b
	);
endinterface : host_port_if

/* File: hdl/host_port_device.sv */
/*
 * Device end of the parallel host port: register file, read drive,
 * clocked reset filter and open-drain interrupt.
 * Assumes host pins are synchronous to i_clk_sys.
 */
`timescale 1ns/1ns
module host_port_device
	import host_port_pkg::*;
(
	input wire logic i_clk_sys, // System clock.
	input wire logic i_rst_b, // Power-on reset, active low.
	host_port_if.device bus, // Pins toward the host.
	input wire logic [NUM_REGS-1:0] i_irq_src, // Interrupt source pulses.
	input wire logic [NUM_REGS-1:0] i_irq_en, // Interrupt enables.
	input wire logic i_irq_clr, // Clears pending interrupts.
	output logic o_soft_reset, // Filtered pin reset level.
	output word_t o_reg_file [NUM_REGS] // Write register contents.
);
	localparam int BYTE_W = DATA_W / 2;
	typedef enum logic [1:0] {SRC_WORD, SRC_LOW, SRC_GP} rd_src_t;
	logic wr_q;
	logic wr_sel;
	logic wr_rise;
	logic rd_sel;
	logic rst_hit;
	logic irq_any;
	logic [RST_CNT_W-1:0] rst_cnt_q;
	logic [NUM_REGS-1:0] irq_set;
	logic [NUM_REGS-1:0] wr_en;
	logic irq_pend_q [NUM_REGS];
	word_t regs_q [NUM_REGS];
	word_t wr_word;
	word_t rd_word;
	word_t rd_q;
	word_t gp_word;
	addr_t eff_addr;
	rd_src_t rd_src;

	/****************************************************************
	 * Pin reset filter.
	 ****************************************************************/
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rst_cnt_q <= '0;
		else if (bus.reset_in_low)
			rst_cnt_q <= '0;
		else if (rst_cnt_q != RST_CNT_LIMIT)
			rst_cnt_q <= rst_cnt_q + RST_CNT_W'(1);
	end

	// Clocked reset only
	// The pin is only sampled on clock edges, so with the clock stopped a
	// low pin changes nothing.
	assign rst_hit = (rst_cnt_q == RST_CNT_LIMIT);
	assign o_soft_reset = rst_hit;

	/****************************************************************
	 * Strobe decode.
	 ****************************************************************/
	// Address decode
	// In wide mode the top address bit is ignored whatever the host drives.
	assign eff_addr = bus.bus_width_select ?
		{1'b0, bus.register_address[ADDR_W-2:0]} : bus.register_address;

	assign wr_sel = !bus.write_strobe_low && !bus.chip_select_low;
	assign rd_sel = !bus.read_strobe_low && !bus.chip_select_low;

	// Remembers a selected low write strobe from the previous edge.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			wr_q <= 1'b0;
		else
			wr_q <= wr_sel;
	end

	// Capture on strobe rise
	// Select must still be low at the rise, so an aborted cycle writes nothing.
	assign wr_rise = wr_q && bus.write_strobe_low && !bus.chip_select_low;

	/****************************************************************
	 * Write path.
	 ****************************************************************/
	// Width selects lanes
	// The upper byte is written as zero in narrow mode.
	always_comb
	begin
		wr_word = bus.host_data_lines;
		if (!bus.bus_width_select)
			wr_word = word_t'(bus.host_data_lines[BYTE_W-1:0]);
	end

	// One write enable for each register.
	always_comb
	begin
		wr_en = '0;
		if (wr_rise)
			wr_en[eff_addr] = 1'b1;
	end

	// A pin reset clears the whole file on every cycle that it persists.
	for (genvar g = 0; g < NUM_REGS; g++)
	begin : g_reg
		always_ff @(posedge i_clk_sys or negedge i_rst_b)
		begin
			if (!i_rst_b)
				regs_q[g] <= REG_RESET_VAL;
			else if (rst_hit)
				regs_q[g] <= REG_RESET_VAL;
			else if (wr_en[g])
				regs_q[g] <= wr_word;
		end
	end
	assign o_reg_file = regs_q;

	/****************************************************************
	 * Read path.
	 ****************************************************************/
	// General inputs status
	// In narrow mode the upper lines are sampled as one byte, and a read of GP_STATUS_ADDR returns them in the low byte.
	assign gp_word = word_t'(bus.host_data_lines[DATA_W-1:BYTE_W]);

	always_comb
	begin
		rd_src = SRC_WORD;
		if (!bus.bus_width_select && eff_addr == GP_STATUS_ADDR)
			rd_src = SRC_GP;
		else if (!bus.bus_width_select)
			rd_src = SRC_LOW;
	end

	always_comb
	begin
		unique case (rd_src)
			SRC_WORD: rd_word = regs_q[eff_addr];
			SRC_LOW: rd_word = word_t'(regs_q[eff_addr][BYTE_W-1:0]);
			SRC_GP: rd_word = gp_word;
			default: rd_word = REG_RESET_VAL;
		endcase
	end

	// Read data leaves from a flop. The address is stable a cycle before
	// the host samples the lines, so the flop costs no extra wait.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rd_q <= REG_RESET_VAL;
		else
			rd_q <= rd_word;
	end
	assign bus.host_data_dev_out = rd_q;

	assign bus.host_data_dev_oe_b = !rd_sel;

	/****************************************************************
	 * Interrupt.
	 ****************************************************************/
	assign irq_set = i_irq_src & i_irq_en;

	// Pending, set wins over clear
	// Each source keeps its flag until a pin reset, or a clear that arrives with no new event.
	for (genvar g = 0; g < NUM_REGS; g++)
	begin : g_irq
		always_ff @(posedge i_clk_sys or negedge i_rst_b)
		begin
			if (!i_rst_b)
				irq_pend_q[g] <= 1'b0;
			else if (rst_hit)
				irq_pend_q[g] <= 1'b0;
			else if (irq_set[g])
				irq_pend_q[g] <= 1'b1;
			else if (i_irq_clr)
				irq_pend_q[g] <= 1'b0;
		end
	end

	always_comb
	begin
		irq_any = 1'b0;
		for (int i = 0; i < NUM_REGS; i++)
			irq_any = irq_any || irq_pend_q[i];
	end

	// The line is open drain: it only ever pulls low or floats.
	assign bus.interrupt_request_out = 1'b0;
	assign bus.interrupt_oe_b = !irq_any;
endmodule : host_port_device

/* File: hdl/host_port_host.sv */
/*
 * Host end of the parallel host port: reset sequencer and one-at-a-time
 * read and write cycles driven by a simple request port.
 * Assumes the device samples pins on the same i_clk_sys.
 */
`timescale 1ns/1ns
module host_port_host
	import host_port_pkg::*;
(
	input wire logic i_clk_sys, // System clock.
	input wire logic i_rst_b, // Reset, active low.
	host_port_if.host bus, // Pins toward the device.
	input wire logic i_wide, // Selects 16-bit bus.
	input wire logic i_req, // Access request.
	input wire logic i_wr, // High for write.
	input wire addr_t i_addr, // Register address.
	input wire word_t i_wdata, // Write data.
	output logic o_ready, // Idle, request accepted.
	output logic o_done, // One-cycle completion pulse.
	output word_t o_rdata, // Read data.
	output logic o_irq // Interrupt pending.
);
	typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_STROBE, ST_END} st_t;
	st_t st_q;
	logic [3:0] cnt_q;
	logic wr_q;
	addr_t addr_q;
	word_t wdata_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_q <= ST_RESET;
			cnt_q <= '0;
		end
		else
		begin
			unique case (st_q)
				ST_RESET:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == HOST_RST_CYCLES)
						st_q <= ST_IDLE;
				end
				ST_IDLE:
				begin
					cnt_q <= '0;
					if (i_req)
						st_q <= ST_STROBE;
				end
				ST_STROBE:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(STROBE_CYCLES - 1))
						st_q <= ST_END;
				end
				ST_END:
					st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
		end
		else if (st_q == ST_IDLE && i_req)
		begin
			wr_q <= i_wr;
			addr_q <= i_wide ? {1'b0, i_addr[ADDR_W-2:0]} : i_addr;
			wdata_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rdata <= '0;
		else if (st_q == ST_STROBE && !wr_q &&
			cnt_q == 4'(STROBE_CYCLES - 1))
			o_rdata <= bus.host_data_lines;
	end

	assign o_ready = (st_q == ST_IDLE);
	assign o_done = (st_q == ST_END);
	assign o_irq = !bus.interrupt_oe_b;
	assign bus.reset_in_low = (st_q != ST_RESET);
	assign bus.bus_width_select = i_wide;
	assign bus.chip_select_low = !(st_q == ST_STROBE || st_q == ST_END);
	assign bus.register_address = addr_q;
	assign bus.host_data_host_out = wdata_q;
	assign bus.host_data_host_oe_b =
		!(wr_q && (st_q == ST_STROBE || st_q == ST_END));
	assign bus.write_strobe_low = !(wr_q && st_q == ST_STROBE);
	assign bus.read_strobe_low = !(!wr_q && st_q == ST_STROBE);
endmodule : host_port_host

/* File: dv/host_port_monitor.sv */
/*
 * Pin-level checker for the parallel host port.
 * Assumes the bench instantiates it beside the interface.
 */
`timescale 1ns/1ns
module host_port_monitor
	import host_port_pkg::*;
(
	input wire logic i_clk_sys, // Clock.
	input wire logic i_rst_b, // Host reset.
	input wire logic chip_select_low, // Select.
	input wire logic write_strobe_low, // Write strobe.
	input wire logic read_strobe_low, // Read strobe.
	input wire logic reset_in_low, // Pin reset.
	input wire logic bus_width_select, // Width.
	input wire addr_t register_address, // Address.
	input wire logic host_data_dev_oe_b, // Device enable.
	input wire logic host_data_host_oe_b, // Host enable.
	input wire logic interrupt_request_out, // Irq level.
	input wire logic interrupt_oe_b // Irq enable.
);
	// ****************
	// Pin properties
	// ****************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	logic rd_sel;
	assign rd_sel = !chip_select_low && !read_strobe_low;
	drive_on_read_a: assert property (
		!host_data_dev_oe_b |-> rd_sel || $past(rd_sel))
		else $error("data driven outside a read");
	float_idle_a: assert property (
		!rd_sel && $past(!rd_sel) |-> host_data_dev_oe_b)
		else $error("data not released");
	one_driver_a: assert property (
		!(!host_data_dev_oe_b && !host_data_host_oe_b))
		else $error("both ends drive data");
	wide_addr_a: assert property (
		bus_width_select && !chip_select_low |-> !register_address[3])
		else $error("top address bit high in wide mode");
	write_hold_a: assert property (
		!write_strobe_low && $past(!write_strobe_low) |->
		!chip_select_low && $stable(register_address))
		else $error("select or address moved in write");
	write_data_a: assert property (
		$rose(write_strobe_low) |->
		$past(!host_data_host_oe_b) && !host_data_host_oe_b)
		else $error("data not driven at write edge");
	select_used_a: assert property (
		!write_strobe_low || !read_strobe_low |-> !chip_select_low)
		else $error("strobe without select");
	irq_low_a: assert property (
		!interrupt_oe_b |-> !interrupt_request_out)
		else $error("interrupt line not pulled low");
	pin_reset_a: assert property (
		$rose(i_rst_b) |-> !reset_in_low [*8])
		else $error("pin reset too short");
	cover property (rd_sel && !bus_width_select);
	cover property ($rose(write_strobe_low) && bus_width_select);
	cover property (!interrupt_oe_b);
endmodule : host_port_monitor

/* File: dv/tb_host_parallel_bus_port.sv */
/*
 * Bench joining host and device ends of the parallel host port.
 * Assumes both ends run on one 100 MHz clock.
 */
`timescale 1ns/1ns
module tb_host_parallel_bus_port;
	import host_port_pkg::*;
	logic clk = 0, rst_h = 0, rst_d = 0, req = 0, wr = 0, wide = 1;
	logic clr = 0, rdy, done, irq, srst;
	addr_t addr = '0;
	word_t wdat = '0, rdat, drv, fl = '0;
	logic [15:0] src = '0, en = '0;
	logic [7:0] gp = '0;
	logic [31:0] seed = 32'h0000002e;
	word_t regs [NUM_REGS];
	word_t eq[$], mq[$];
	int fail_count = 0, n_compared = 0, cyc = 0;
	host_port_if h();
	// Undriven wires show a changing pattern; narrow mode upper byte is gp.
	assign drv = !h.host_data_dev_oe_b ? h.host_data_dev_out :
		!h.host_data_host_oe_b ? h.host_data_host_out : fl;
	assign h.host_data_lines = {wide ? drv[15:8] : gp, drv[7:0]};
	always #5 clk = ~clk;
	always @(posedge clk) fl <= fl + 16'h1357;
	host_port_device u_host_port_device (.i_clk_sys(clk), .i_rst_b(rst_d),
		.bus(h.device), .i_irq_src(src), .i_irq_en(en), .i_irq_clr(clr),
		.o_soft_reset(srst), .o_reg_file(regs));
	host_port_host u_host_port_host (.i_clk_sys(clk), .i_rst_b(rst_h),
		.bus(h.host), .i_wide(wide), .i_req(req), .i_wr(wr), .i_addr(addr),
		.i_wdata(wdat), .o_ready(rdy), .o_done(done), .o_rdata(rdat),
		.o_irq(irq));
	host_port_monitor u_host_port_monitor (.i_clk_sys(clk), .i_rst_b(rst_h),
		.chip_select_low(h.chip_select_low),
		.write_strobe_low(h.write_strobe_low),
		.read_strobe_low(h.read_strobe_low), .reset_in_low(h.reset_in_low),
		.bus_width_select(h.bus_width_select),
		.register_address(h.register_address),
		.host_data_dev_oe_b(h.host_data_dev_oe_b),
		.host_data_host_oe_b(h.host_data_host_oe_b),
		.interrupt_request_out(h.interrupt_request_out),
		.interrupt_oe_b(h.interrupt_oe_b));
	function word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	task chk(input string n, input word_t e, input word_t s);
		n_compared++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task final_report();
		chk("pending reads", 16'h0000, word_t'(eq.size()));
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task acc(input logic w, input addr_t a, input word_t d, input word_t m);
		@(negedge clk);
		req = 1;
		wr = w;
		addr = a;
		wdat = d;
		for (int i = 0; i < 30 && rdy !== 1'b1; i++) @(negedge clk);
		if (!w)
		begin
			eq.push_back(d);
			mq.push_back(m);
		end
		@(negedge clk);
		req = 0;
		for (int i = 0; i < 10 && done !== 1'b1; i++) @(negedge clk);
		repeat (3) @(negedge clk);
		// write lands in the addressed register
		if (w) chk("reg", wide ? d : {8'h00, d[7:0]},
			regs[wide ? {1'b0, a[2:0]} : a]);
	endtask : acc
	always @(negedge clk)
	begin
		if (done === 1'b1 && eq.size() > 0)
			chk("rdata", eq.pop_front(), rdat & mq.pop_front());
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			final_report();
		end
	end
	initial
	begin
		word_t d;
		int k;
		d = rnd();
		gp = d[7:0];
		repeat (16) @(negedge clk);
		rst_h = 1;
		rst_d = 1;
		for (k = 0; k < 8; k++)
		begin
			d = rnd();
			if (k != 5) acc(1, k[3:0], d, '0);
			if (k != 5) acc(0, k[3:0], d, 16'hffff);
		end
		d = rnd();
		acc(1, 4'hb, d, '0);
		acc(0, 4'h3, d, 16'hffff);
		@(negedge clk) wide = 0;
		for (k = 0; k < 16; k++)
		begin
			d = rnd();
			if (k != 5) acc(1, k[3:0], d, '0);
			if (k != 5) acc(0, k[3:0], {8'h00, d[7:0]}, 16'h00ff);
		end
		acc(0, GP_STATUS_ADDR, {8'h00, gp}, 16'h00ff);
		@(negedge clk) en = 16'h0004;
		src = 16'h0001;
		@(negedge clk) src = '0;
		repeat (4) @(negedge clk);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		src = 16'h0004;
		@(negedge clk) src = '0;
		for (k = 0; k < 8 && irq !== 1'b1; k++) @(negedge clk);
		chk("irq pin", 16'h0000, {15'h0000, h.interrupt_oe_b});
		clr = 1;
		@(negedge clk) clr = 0;
		for (k = 0; k < 8 && irq !== 1'b0; k++) @(negedge clk);
		chk("irq release", 16'h0001, {15'h0000, h.interrupt_oe_b});
		@(negedge clk) rst_h = 0;
		@(negedge clk) rst_h = 1;
		for (k = 0; k < 30 && srst !== 1'b1; k++) @(negedge clk);
		chk("soft reset", 16'h0001, {15'h0000, srst});
		for (k = 0; k < 30 && rdy !== 1'b1; k++) @(negedge clk);
		for (k = 0; k < NUM_REGS; k++) chk("clear", REG_RESET_VAL, regs[k]);
		final_report();
	end
endmodule : tb_host_parallel_bus_port
